// *** hdl/cvs_stepper.sv ***
// Core voltage code stepper with strap capture and core ratio select.
// Assumes the code pins are two-way: sampled after reset release, driven afterwards.
`timescale 1ns/100ps
module cvs_stepper
    import cvs_pkg::*;
#(
    parameter logic [7:0] DEF_CODE   = 8'h20,  // Per-part default code
    parameter logic [7:0] MAX_CODE   = 8'h10,  // Highest voltage allowed (lowest code)
    parameter logic [7:0] MAX_RATIO  = 8'h18   // Manufacturing maximum ratio
) (
    input  wire logic                 mclk_in,          // 10 MHz clock
    input  wire logic                 rst_b_in,         // Async reset, active low
    input  wire logic [7:0]           code_pin_in,      // Code pin levels
    output logic      [7:0]           code_pin_out,     // Code pin drive
    output logic      [7:0]           code_pin_oe_out,  // Code pin enable
    input  wire logic [7:0]           target_code_in,   // Thermal/load target
    input  wire logic [7:0]           ratio_limit_in,   // Ratio limit value
    input  wire logic                 ratio_limit_wr_in,// Ratio limit write pulse
    input  wire logic [7:0]           ratio_req_in,     // Requested core ratio
    output logic      [2:0]           strap_group_upper_out, // Straps from lines 5:3
    output logic      [2:0]           strap_group_lower_out, // Straps from lines 2:0
    output logic      [7:0]           core_ratio_out,   // Selected ratio
    output logic      [15:0]          core_mhz_out,     // Ratio times base clock
    output logic                      stepping_out      // Code not at target
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release and strap capture
    logic       run;
    logic [7:0] pin_s1, pin_s2, pin_s3;
    logic [7:0] core_voltage_code;
    logic [7:0] ratio_max;
    logic [7:0] core_ratio;
    logic [15:0] core_mhz;
    logic [1:0] fill;
    logic [$clog2(CVS_STEP_CYC+1)-1:0] step_cnt;

    // Three-stage pin sampler; stage one only feeds stage two
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_s1 <= CVS_CODE_RST;
            pin_s2 <= CVS_CODE_RST;
            pin_s3 <= CVS_CODE_RST;
        end else begin
            pin_s1 <= code_pin_in;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Edges since release, until every sampler stage holds a real pin sample.
    // The stages all reset to the same value, so without this count the
    // reset contents would pass as agreeing straps at the first edge.
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fill <= '0;
        end else if (fill != 2'(CVS_SYNC_STAGES)) begin
            fill <= 2'(fill + 2'h1);
        end
    end

    // Straps taken once the sampler is full and its last two stages agree
    wire strap_ok = (fill == 2'(CVS_SYNC_STAGES)) && (pin_s2 == pin_s3);

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            run                   <= 1'b0;
            strap_group_upper_out <= CVS_STRAP_RST;
            strap_group_lower_out <= CVS_STRAP_RST;
        end else if (!run && strap_ok) begin
            run                   <= 1'b1;
            strap_group_upper_out <= pin_s3[5:3];
            strap_group_lower_out <= pin_s3[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive: released during reset and strap sampling
    assign code_pin_out    = core_voltage_code;
    assign code_pin_oe_out = {CVS_CODE_W{run}};

    ////////////////////////////////////////////////////////////////////////
    // Target clamp and stepping
    // Lower code is higher voltage; never ask above the part maximum
    wire [7:0] clamp_tgt  = (target_code_in < MAX_CODE) ? MAX_CODE : target_code_in;
    wire       step_due   = (step_cnt == '0);
    wire       go_up      = (core_voltage_code < clamp_tgt);
    wire       go_dn      = (core_voltage_code > clamp_tgt);
    wire [7:0] next_code  = go_up ? 8'(core_voltage_code + 8'h01)
                          : go_dn ? 8'(core_voltage_code - 8'h01) : core_voltage_code;

    // One step per interval, then wait the full interval
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_voltage_code <= DEF_CODE;
            step_cnt          <= '0;
        end else if (run) begin
            if (!step_due) begin
                step_cnt <= step_cnt - 1'b1;
            end else if (go_up || go_dn) begin
                core_voltage_code <= next_code;
                step_cnt <= ($bits(step_cnt))'(CVS_STEP_CYC - 1);
            end
        end
    end

    assign stepping_out = (core_voltage_code != clamp_tgt);

    ////////////////////////////////////////////////////////////////////////
    // Core ratio: manufacturing maximum, lowered by a limit write
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ratio_max  <= CVS_RATIO_RST;
            core_ratio <= CVS_RATIO_RST;
        end else begin
            if (!run) begin
                ratio_max <= MAX_RATIO;
            end else if (ratio_limit_wr_in && ratio_limit_in < ratio_max) begin
                ratio_max <= ratio_limit_in;
            end
            core_ratio <= (ratio_req_in > ratio_max) ? ratio_max : ratio_req_in;
        end
    end

    // Frequency held in a register so the output never shows a partial product
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            core_mhz <= CVS_MHZ_RST;
        end else begin
            core_mhz <= 16'(core_ratio * CVS_BASE_MHZ);
        end
    end

    assign core_ratio_out = core_ratio;
    assign core_mhz_out   = core_mhz;

    ////////////////////////////////////////////////////////////////////////
    // Interval watch: edges seen since the code last moved, counted apart
    // from the step counter so that a broken reload still shows up
    logic [7:0]                        code_seen;
    logic [$clog2(CVS_STEP_CYC+1)-1:0] since_move;
    wire                               code_moved = (core_voltage_code != code_seen);

    // Saturates at one full interval; restarts at one after each move
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            code_seen  <= DEF_CODE;
            since_move <= ($bits(since_move))'(CVS_STEP_CYC);
        end else begin
            code_seen <= core_voltage_code;
            if (code_moved) begin
                since_move <= ($bits(since_move))'(1);
            end else if (since_move != ($bits(since_move))'(CVS_STEP_CYC)) begin
                since_move <= ($bits(since_move))'(since_move + 1'b1);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_ONE_STEP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $changed(core_voltage_code) |->
            (core_voltage_code == $past(core_voltage_code) + 8'h01) ||
            (core_voltage_code == $past(core_voltage_code) - 8'h01))
        else $error("code moved more than one step");
    // A move is only legal once a whole interval has passed since the last one
    AST_STEP_GAP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        code_moved |-> since_move >= CVS_STEP_CYC)
        else $error("code changed within one interval");
    AST_MAX_V: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run && $changed(core_voltage_code) |-> core_voltage_code >= MAX_CODE)
        else $error("code stepped above the voltage maximum");
    AST_TOWARD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run && stepping_out && step_due |=> $changed(core_voltage_code))
        else $error("code did not step toward target");
    AST_DRIVE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run |-> code_pin_oe_out == 8'hFF && code_pin_out == core_voltage_code)
        else $error("code pins not driven");
    AST_STRAP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !run && strap_ok |=> strap_group_upper_out == $past(pin_s3[5:3]) &&
                             strap_group_lower_out == $past(pin_s3[2:0]))
        else $error("straps not captured");
    AST_RATIO: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run |-> core_ratio_out <= ratio_max && ratio_max <= MAX_RATIO)
        else $error("ratio above its limit");
    // Frequency register follows the ratio one edge later
    AST_FREQ: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        core_mhz_out == 16'($past(core_ratio_out) * CVS_BASE_MHZ))
        else $error("frequency not ratio times base");

    // Default code stands until the straps are in
    AST_HOLD_DEF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !run |-> core_voltage_code == DEF_CODE)
        else $error("code left its default before start");

    // Lines stay released while they are read as straps
    AST_RELEASED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !run |-> code_pin_oe_out == 8'h00)
        else $error("code pins driven during strap sampling");

    // Straps keep their captured value for the rest of the run
    AST_STRAP_KEEP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run |=> $stable(strap_group_upper_out) && $stable(strap_group_lower_out))
        else $error("straps changed after capture");

    // Manufacturing maximum is loaded before the run starts
    AST_RATIO_LOAD: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !run |=> ratio_max == MAX_RATIO)
        else $error("ratio maximum not loaded");

    // A limit write can only lower the ratio maximum
    AST_LIMIT_DOWN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run |=> ratio_max <= $past(ratio_max))
        else $error("ratio maximum rose");

    // No move once the code sits on its clamped target
    AST_SETTLED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run && !stepping_out |=> $stable(core_voltage_code))
        else $error("code moved while on target");

    // A settled code never asks for more than the part maximum voltage
    AST_CLAMP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        run && !stepping_out |-> core_voltage_code >= MAX_CODE)
        else $error("settled code above the voltage maximum");

endmodule

// *** hdl/cvs_pkg.sv ***
// Constants for the core voltage code stepper.
// Assumes a single 10 MHz clock and an active-low asynchronous reset.
//
// Operation
// - The block drives an eight-bit core voltage code on its own output lines to the regulator.
// - A code bit of one is driven high and a code bit of zero is driven low.
// - The code changes by at most one step in each 1.25 microsecond interval.
// - The code walks through every intermediate value until it reaches the target.
// - The code never moves to a value that requests more voltage than the part maximum.
// - The target code follows the temperature and load request so as to save power.
// - Code lines five to three and two to zero are sampled as straps after reset release, then driven.
// - The block keeps running while the code steps to an adjacent value.
// - The default code is a per-part value fixed at manufacture.
// - Core frequency is the selected ratio times the 133 MHz base clock.
// - The maximum ratio loads from a manufacturing default before the run starts and a limit may lower it.
package cvs_pkg;
    localparam int          CVS_CODE_W      = 8;
    localparam int          CVS_RATIO_W     = 8;
    localparam int          CVS_STRAP_W     = 3;
    localparam int          CVS_CLK_KHZ     = 10000;
    localparam int          CVS_STEP_NS     = 1250;
    // Least interval rounds up to whole cycles
    localparam int          CVS_STEP_CYC    = (CVS_STEP_NS * CVS_CLK_KHZ + 999999) / 1000000;
    localparam int          CVS_BASE_MHZ    = 133;
    localparam int          CVS_SYNC_STAGES = 3;
    localparam logic [15:0] CVS_MHZ_RST     = 16'h0000;
    localparam logic [7:0]  CVS_CODE_OFF    = 8'h01;
    localparam logic [7:0]  CVS_CODE_RST    = 8'h00;
    localparam logic [2:0]  CVS_STRAP_RST   = 3'h0;
    localparam logic [7:0]  CVS_RATIO_RST   = 8'h00;
endpackage

// *** test/cvs_regulator.sv ***
// Behavioural regulator on the far side of the code lines.
// Assumes the lines carry the resolved pin levels.
`timescale 1ns/100ps
module cvs_regulator (
    input  wire logic [7:0] code_in,     // Code seen on the lines
    output int              vout_uv_out  // Requested output, microvolts
);
    // Code to voltage; off codes and the empty socket give no output
    always_comb begin
        if (code_in < 8'h02 || code_in == 8'hFF) begin
            vout_uv_out = 0;
        end else begin
            vout_uv_out = 1600000 - (int'(code_in) - 2) * 6250;
        end
    end
endmodule

// *** test/core_voltage_code_stepper_bench.sv ***
// Self-checking bench for the code stepper with a regulator model.
// Assumes straps are board levels seen while the code lines are not driven.
`timescale 1ns/100ps
module core_voltage_code_stepper_bench;
    import cvs_pkg::*;
    localparam logic [7:0] DEF = 8'h20, MAXC = 8'h10, MAXR = 8'h18;
    logic        mclk_in = 0, rst_b_in = 0, wr = 0, stp;
    logic [7:0]  pin_out, oe, ratio, tgt = DEF, lim = 8'h00, req = 8'h00, strap, prev = DEF;
    logic [7:0]  rmax = MAXR, rexp;
    logic [2:0]  up, lo;
    logic [15:0] mhz;
    logic [31:0] lfsr = 32'hD2981B67;
    int          vout, failures = 0, compares = 0, gap = 0, i, k;
    wire  logic [7:0] pins = (oe & pin_out) | (~oe & strap);
    always #50 mclk_in = ~mclk_in;
    cvs_stepper #(.DEF_CODE(DEF), .MAX_CODE(MAXC), .MAX_RATIO(MAXR)) i_dut (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .code_pin_in(pins), .code_pin_out(pin_out),
        .code_pin_oe_out(oe), .target_code_in(tgt), .ratio_limit_in(lim),
        .ratio_limit_wr_in(wr), .ratio_req_in(req), .strap_group_upper_out(up),
        .strap_group_lower_out(lo), .core_ratio_out(ratio), .core_mhz_out(mhz),
        .stepping_out(stp));
    cvs_regulator i_reg (.code_in(pins), .vout_uv_out(vout));
    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Requested voltage in 0.625 mV units: off codes, then 1.6 V less 6.25 mV a step
    function automatic logic [15:0] volt_steps(input logic [7:0] code);
        if (code < 8'h02 || code == 8'hFF) begin
            return 16'h0000;
        end
        return 16'(2560 - (int'(code) - 2) * 10);
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic wrap_up;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Every code change is one step, spaced by the interval, inside the limit
    always @(posedge mclk_in) begin
        #2;
        gap++;
        if (oe === 8'hFF && pin_out !== prev) begin
            check("step", {8'h00, (pin_out > prev) ? pin_out - prev : prev - pin_out}, 16'h1);
            check("spacing", {15'h0, gap >= CVS_STEP_CYC}, 16'h1);
            check("limit", {15'h0, pin_out >= MAXC}, 16'h1);
            prev = pin_out;
            gap = 0;
        end
    end
    // Hang guard
    initial begin
        #3000000;
        failures++;
        wrap_up();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: straps, stepping, ratio limit
    initial begin
        strap = lfsr[7:0];
        repeat (10) @(posedge mclk_in);
        #1 rst_b_in = 1;
        for (i = 0; i < 20 && oe !== 8'hFF; i++) tick();
        check("enable", {8'h00, oe}, 16'h00FF);
        check("upper straps", {13'h0, up}, {13'h0, strap[5:3]});
        check("lower straps", {13'h0, lo}, {13'h0, strap[2:0]});
        check("default code", {8'h00, pin_out}, {8'h00, DEF});
        for (k = 0; k < 8; k++) begin
            lfsr = next_rand(lfsr);
            tgt = (k == 0) ? 8'h21 : (k == 1) ? 8'h05 : {3'h0, lfsr[4:0]} + 8'h10;
            rexp = (tgt < MAXC) ? MAXC : tgt;
            for (i = 0; i < 1000 && (stp !== 1'b0 || pin_out !== rexp); i++) tick();
            check("settled code", {8'h00, pin_out}, {8'h00, rexp});
            check("regulator", 16'(vout / 625), volt_steps(rexp));
        end
        for (k = 0; k < 6; k++) begin
            lfsr = next_rand(lfsr);
            req = (k == 0) ? 8'hFF : {3'h0, lfsr[4:0]};
            wr = (k == 2 || k == 4);
            lim = (k == 2) ? 8'h10 : 8'h14;
            tick();
            wr = 0;
            tick();
            tick();
            rmax = (k >= 2) ? 8'h10 : MAXR;
            rexp = (req < rmax) ? req : rmax;
            check("ratio", {8'h00, ratio}, {8'h00, rexp});
            check("frequency", mhz, 16'(rexp) * 16'd133);
        end
        wrap_up();
    end
endmodule
